// [rtl/cci_codec.sv]
// rate 1/2 coder, matrix interleaver and trellis decoder for the packet path
// assumes fixed-length packets of 2..64 bytes, length stable from start to done
`default_nettype none
module cci_codec
  import cci_pkg::*;
(
  // clock, reset, enable
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       ce,
  // configuration
  input  wire logic       coding_enable,
  input  wire logic [1:0] packet_length_mode,
  input  wire logic [6:0] pkt_len,
  // transmit bytes from packet handler
  input  wire logic       tx_start,
  input  var  cci_byte_t  tx_byte_in,
  output logic            tx_byte_ready,
  // transmit bits to modulator
  output cci_bit_t        tx_bit_out,
  input  wire logic       tx_bit_ready,
  output logic            tx_done,
  // receive bits from demodulator
  input  wire logic       rx_start,
  input  var  cci_bit_t   rx_bit_in,
  output logic            rx_bit_ready,
  // receive bytes to FIFO
  output cci_byte_t       rx_byte_out,
  input  wire logic       rx_byte_ready,
  output logic            rx_done
);
  // ------------------------------------------------------------
  // shared decode
  // ------------------------------------------------------------
  // packet_length_mode is the partner's to keep fixed; only coding_enable steers
  wire        mode_fixed = packet_length_mode == CCI_LEN_FIXED;
  // coding selected per packet at start
  wire        fec_now    = coding_enable;
  // odd length gets one pad byte, even gets two
  wire  [7:0] total_fec  = {1'b0, pkt_len} + (pkt_len[0] ? 8'h01 : 8'h02);

  // ------------------------------------------------------------
  // transmit
  // ------------------------------------------------------------
  cci_tx_state_t tx_st_reg;
  logic          tx_fec_reg;
  logic [6:0]    tx_len_reg;
  logic [7:0]    tx_total_reg;
  logic [7:0]    tx_cnt_reg;
  logic [7:0]    tx_sh_reg;
  logic [2:0]    enc_sr_reg;
  logic [3:0]    tx_k_reg;
  logic          tx_il_bit;
  cci_bit_t      tx_out_reg;

  wire       tx_is_pad  = tx_cnt_reg >= {1'b0, tx_len_reg};
  wire       tx_is_last = tx_cnt_reg == tx_total_reg;
  // one input bit makes two coded bits
  wire [3:0] enc_win    = {tx_sh_reg[7], enc_sr_reg};
  wire       enc_c0     = ^(enc_win & CCI_G0);
  wire       enc_c1     = ^(enc_win & CCI_G1);
  wire       tx_slot    = !tx_out_reg.valid || tx_bit_ready;
  wire       tx_src     = tx_fec_reg ? tx_il_bit : tx_sh_reg[7];
  wire [3:0] tx_last_k  = tx_fec_reg ? CCI_CODED_LAST : CCI_RAW_LAST;
  wire       tx_load    = tx_st_reg == TX_SEND && tx_slot;

  assign tx_byte_ready = tx_st_reg == TX_FETCH && !tx_is_pad;
  assign tx_bit_out    = tx_out_reg;

  // rows written by coder, columns sent
  cci_matrix #(.WRITE_BY_ROW(1'b1)) u_tx_matrix (
    .mclk   (mclk),
    .sys_rst(sys_rst),
    .ce     (ce),
    .wr_en  (tx_st_reg == TX_ENC),
    .wr_idx (tx_k_reg),
    .wr_bit (tx_k_reg[0] ? enc_c1 : enc_c0),
    .rd_idx (tx_k_reg),
    .rd_bit (tx_il_bit)
  );

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      tx_st_reg    <= TX_IDLE;
      tx_fec_reg   <= 1'b0;
      tx_len_reg   <= 7'h00;
      tx_total_reg <= 8'h00;
      tx_cnt_reg   <= 8'h00;
      tx_sh_reg    <= 8'h00;
      enc_sr_reg   <= 3'h0;
      tx_k_reg     <= 4'h0;
      tx_out_reg   <= '0;
      tx_done      <= 1'b0;
    end
    else if (ce)
    begin
      tx_done <= 1'b0;
      if (tx_load)
        tx_out_reg <= '{valid: 1'b1, bit_val: tx_src};
      else if (tx_bit_ready)
        tx_out_reg.valid <= 1'b0;
      case (tx_st_reg)
        TX_IDLE:
          if (tx_start)
          begin
            tx_fec_reg   <= fec_now;
            tx_len_reg   <= pkt_len;
            tx_total_reg <= fec_now ? total_fec : {1'b0, pkt_len};
            tx_cnt_reg   <= 8'h00;
            // coder starts from the zero state
            enc_sr_reg   <= 3'h0;
            tx_st_reg    <= TX_FETCH;
          end
        TX_FETCH:
        begin
          tx_k_reg <= 4'h0;
          if (tx_is_last)
          begin
            tx_done   <= 1'b1;
            tx_st_reg <= TX_IDLE;
          end
          // zero pad bytes flush the coder
          else if (tx_is_pad)
          begin
            tx_sh_reg <= 8'h00;
            tx_st_reg <= TX_ENC;
          end
          else if (tx_byte_in.valid)
          begin
            tx_sh_reg <= tx_byte_in.data;
            tx_st_reg <= tx_fec_reg ? TX_ENC : TX_SEND;
          end
        end
        TX_ENC:
        begin
          // c0 then c1 for each bit, msb first
          tx_k_reg <= tx_k_reg + 4'h1;
          if (tx_k_reg[0])
          begin
            enc_sr_reg <= {enc_sr_reg[1:0], tx_sh_reg[7]};
            tx_sh_reg  <= {tx_sh_reg[6:0], 1'b0};
          end
          if (tx_k_reg == CCI_CODED_LAST)
            tx_st_reg <= TX_SEND;
        end
        TX_SEND:
          if (tx_slot)
          begin
            tx_k_reg <= tx_k_reg + 4'h1;
            if (!tx_fec_reg)
              tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
            if (tx_k_reg == tx_last_k)
            begin
              tx_cnt_reg <= tx_cnt_reg + 8'h01;
              tx_st_reg  <= TX_FETCH;
            end
          end
        default:
          tx_st_reg <= TX_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // receive
  // ------------------------------------------------------------
  cci_rx_state_t rx_st_reg;
  logic          rx_fec_reg;
  logic [6:0]    rx_len_reg;
  logic [7:0]    rx_total_reg;
  logic [7:0]    rx_cnt_reg;
  logic [3:0]    rx_k_reg;
  logic [7:0]    rx_sh_reg;
  logic          rx_sym0_reg;
  logic [9:0]    rx_step_reg;
  logic [2:0]    tb_st_reg;
  logic          rx_il_bit;
  cci_byte_t     rx_out_reg;
  logic [7:0]    pm_reg   [8];
  logic [7:0]    pm_new   [8];
  logic [7:0]    dec_w;
  logic [7:0]    hi_w;
  // decisions for the whole packet, traced back once it is in
  logic [7:0]    dec_mem  [CCI_MAX_STEPS];
  logic [7:0]    rx_buf   [CCI_MAX_BYTES];

  wire       rx_slot  = !rx_out_reg.valid || rx_byte_ready;
  wire       rx_take  = rx_bit_in.valid && rx_bit_ready;
  wire       acs_go   = rx_st_reg == RX_ACS && rx_k_reg[0];
  wire       all_hi   = &hi_w;
  // traceback at step register k handles trellis step k-1
  wire [9:0] tb_idx   = rx_step_reg - 10'h001;
  wire [7:0] dec_now  = dec_mem[tb_idx];
  // only the first pkt_len bytes are emitted
  wire       emit_end = rx_cnt_reg == {1'b0, rx_len_reg};

  assign rx_bit_ready = rx_st_reg == RX_RECV;
  assign rx_byte_out  = rx_out_reg;

  // columns filled from the air, rows to the decoder
  cci_matrix #(.WRITE_BY_ROW(1'b0)) u_rx_matrix (
    .mclk   (mclk),
    .sys_rst(sys_rst),
    .ce     (ce),
    .wr_en  (rx_take && rx_fec_reg),
    .wr_idx (rx_k_reg),
    .wr_bit (rx_bit_in.bit_val),
    .rd_idx (rx_k_reg),
    .rd_bit (rx_il_bit)
  );

  // add-compare-select, predecessors {p, s[2:1]} with input s[0]
  for (genvar s = 0; s < 8; s++)
  begin : g_acs
    localparam logic [3:0] WA = {(s % 2) != 0, 1'b0, 2'(s >> 1)};
    localparam logic [3:0] WB = {(s % 2) != 0, 1'b1, 2'(s >> 1)};
    wire [1:0] bm_a  = {1'b0, (^(WA & CCI_G0)) ^ rx_sym0_reg}
                     + {1'b0, (^(WA & CCI_G1)) ^ rx_il_bit};
    wire [1:0] bm_b  = {1'b0, (^(WB & CCI_G0)) ^ rx_sym0_reg}
                     + {1'b0, (^(WB & CCI_G1)) ^ rx_il_bit};
    wire [7:0] cnd_a = pm_reg[WA[2:0]] + {6'h00, bm_a};
    wire [7:0] cnd_b = pm_reg[WB[2:0]] + {6'h00, bm_b};
    assign dec_w[s]  = cnd_b < cnd_a;
    assign pm_new[s] = dec_w[s] ? cnd_b : cnd_a;
    assign hi_w[s]   = pm_new[s][7];

    // metric spread stays small, so dropping the shared top bit is lossless
    always_ff @(posedge mclk)
    begin
      if (sys_rst)
        pm_reg[s] <= CCI_PM_START;
      else if (ce && rx_st_reg == RX_IDLE && rx_start)
        pm_reg[s] <= (s == 0) ? CCI_PM_START : CCI_PM_BAD;
      else if (ce && acs_go)
        pm_reg[s] <= {pm_new[s][7] & !all_hi, pm_new[s][6:0]};
    end
  end

  // no reset: contents are always written before they are read
  always_ff @(posedge mclk)
  begin
    if (ce && acs_go)
      dec_mem[rx_step_reg] <= dec_w;
    if (ce && rx_st_reg == RX_TRACE)
      rx_buf[tb_idx[9:3]][~tb_idx[2:0]] <= tb_st_reg[0];
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rx_st_reg    <= RX_IDLE;
      rx_fec_reg   <= 1'b0;
      rx_len_reg   <= 7'h00;
      rx_total_reg <= 8'h00;
      rx_cnt_reg   <= 8'h00;
      rx_k_reg     <= 4'h0;
      rx_sh_reg    <= 8'h00;
      rx_sym0_reg  <= 1'b0;
      rx_step_reg  <= 10'h000;
      tb_st_reg    <= 3'h0;
      rx_out_reg   <= '0;
      rx_done      <= 1'b0;
    end
    else if (ce)
    begin
      rx_done <= 1'b0;
      if (rx_byte_ready)
        rx_out_reg.valid <= 1'b0;
      case (rx_st_reg)
        RX_IDLE:
          if (rx_start)
          begin
            rx_fec_reg   <= fec_now;
            rx_len_reg   <= pkt_len;
            rx_total_reg <= fec_now ? total_fec : {1'b0, pkt_len};
            rx_cnt_reg   <= 8'h00;
            rx_k_reg     <= 4'h0;
            rx_step_reg  <= 10'h000;
            rx_st_reg    <= RX_RECV;
          end
        RX_RECV:
          if (rx_take)
          begin
            rx_k_reg  <= rx_k_reg + 4'h1;
            rx_sh_reg <= {rx_sh_reg[6:0], rx_bit_in.bit_val};
            if (rx_fec_reg && rx_k_reg == CCI_CODED_LAST)
              rx_st_reg <= RX_ACS;
            else if (!rx_fec_reg && rx_k_reg == CCI_RAW_LAST)
              rx_st_reg <= RX_RAW;
          end
        RX_ACS:
        begin
          // pairs of row-order symbols feed one trellis step
          rx_k_reg    <= rx_k_reg + 4'h1;
          rx_sym0_reg <= rx_il_bit;
          if (rx_k_reg[0])
            rx_step_reg <= rx_step_reg + 10'h001;
          if (rx_k_reg == CCI_CODED_LAST)
          begin
            rx_cnt_reg <= rx_cnt_reg + 8'h01;
            rx_st_reg  <= RX_RECV;
            if (rx_cnt_reg + 8'h01 == rx_total_reg)
            begin
              // terminated trellis ends in state zero
              tb_st_reg  <= 3'h0;
              rx_st_reg  <= RX_TRACE;
            end
          end
        end
        RX_TRACE:
        begin
          // step register starts one past the last step; stop after step zero
          rx_step_reg <= rx_step_reg - 10'h001;
          tb_st_reg   <= {dec_now[tb_st_reg], tb_st_reg[2:1]};
          rx_cnt_reg  <= 8'h00;
          if (rx_step_reg == 10'h001)
            rx_st_reg <= RX_EMIT;
        end
        RX_EMIT:
          if (rx_slot)
          begin
            if (emit_end)
            begin
              rx_done   <= 1'b1;
              rx_st_reg <= RX_IDLE;
            end
            else
            begin
              rx_out_reg <= '{valid: 1'b1, data: rx_buf[rx_cnt_reg[6:0]]};
              rx_cnt_reg <= rx_cnt_reg + 8'h01;
            end
          end
        RX_RAW:
          if (rx_slot)
          begin
            rx_out_reg <= '{valid: 1'b1, data: rx_sh_reg};
            rx_cnt_reg <= rx_cnt_reg + 8'h01;
            rx_k_reg   <= 4'h0;
            rx_st_reg  <= RX_RECV;
            if (rx_cnt_reg + 8'h01 == rx_total_reg)
            begin
              rx_done   <= 1'b1;
              rx_st_reg <= RX_IDLE;
            end
          end
        default:
          rx_st_reg <= RX_IDLE;
      endcase
    end
  end

  // payload floor is the partner's; mode_fixed is left for observation only
  wire unused_ok = mode_fixed;
endmodule
`default_nettype wire

// [rtl/cci_matrix.sv]
// 4 x 4 bit matrix for interleaving: serial write in one order, read in the other
// assumes the owner sequences the indices and never reads a cell mid-write
`default_nettype none
module cci_matrix
  import cci_pkg::*;
#(
  parameter bit WRITE_BY_ROW = 1'b1
)
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       ce,
  // write side
  input  wire logic       wr_en,
  input  wire logic [3:0] wr_idx,
  input  wire logic       wr_bit,
  // read side
  input  wire logic [3:0] rd_idx,
  output logic            rd_bit
);
  logic [15:0] cell_reg;
  wire  [3:0]  wr_cell = WRITE_BY_ROW ? wr_idx : {wr_idx[1:0], wr_idx[3:2]};
  wire  [3:0]  rd_cell = WRITE_BY_ROW ? {rd_idx[1:0], rd_idx[3:2]} : rd_idx;

  assign rd_bit = cell_reg[rd_cell];

  // ------------------------------------------------------------
  // cells, row r column c at position 4r+c
  // ------------------------------------------------------------
  for (genvar i = 0; i < 16; i++)
  begin : g_cell
    always_ff @(posedge mclk)
    begin
      if (sys_rst)
        cell_reg[i] <= 1'b0;
      else if (ce && wr_en && wr_cell == 4'(i))
        cell_reg[i] <= wr_bit;
    end
  end
endmodule
`default_nettype wire

// [rtl/cci_pkg.sv]
// package for the coded radio path: code constants, sizes, carriers, states
// assumes one mclk domain and fixed-length packets of at most 64 bytes
`default_nettype none
package cci_pkg;
  // ------------------------------------------------------------
  // code and sizes
  // ------------------------------------------------------------
  localparam logic [3:0] CCI_G0         = 4'hf;
  localparam logic [3:0] CCI_G1         = 4'hb;
  localparam int         CCI_MAX_LEN    = 64;
  localparam int         CCI_MAX_BYTES  = CCI_MAX_LEN + 2;
  localparam int         CCI_MAX_STEPS  = CCI_MAX_BYTES * 8;
  localparam logic [3:0] CCI_CODED_LAST = 4'hf;
  localparam logic [3:0] CCI_RAW_LAST   = 4'h7;
  localparam logic [7:0] CCI_PM_START   = 8'h00;
  localparam logic [7:0] CCI_PM_BAD     = 8'h40;
  localparam logic [1:0] CCI_LEN_FIXED  = 2'h0;

  // ------------------------------------------------------------
  // carriers and states
  // ------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } cci_byte_t;

  typedef struct packed {
    logic valid;
    logic bit_val;
  } cci_bit_t;

  typedef enum logic [3:0] {
    TX_IDLE  = 4'b0001,
    TX_FETCH = 4'b0010,
    TX_ENC   = 4'b0100,
    TX_SEND  = 4'b1000
  } cci_tx_state_t;

  typedef enum logic [5:0] {
    RX_IDLE  = 6'b000001,
    RX_RECV  = 6'b000010,
    RX_ACS   = 6'b000100,
    RX_TRACE = 6'b001000,
    RX_EMIT  = 6'b010000,
    RX_RAW   = 6'b100000
  } cci_rx_state_t;
endpackage
`default_nettype wire

// [verification/cci_codec_asserts.sv]
// checker for the coded radio path, bound to the codec top
// assumes ce held high by the bench and one mclk domain
`default_nettype none
module cci_codec_asserts
  import cci_pkg::*;
(
  // clock and reset
  input wire logic       mclk,
  input wire logic       sys_rst,
  input wire logic       ce,
  // configuration
  input wire logic       coding_enable,
  input wire logic [6:0] pkt_len,
  // transmit
  input wire logic       tx_start,
  input var  cci_byte_t  tx_byte_in,
  input wire logic       tx_byte_ready,
  input var  cci_bit_t   tx_bit_out,
  input wire logic       tx_bit_ready,
  input wire logic       tx_done,
  // receive
  input wire logic       rx_start,
  input var  cci_bit_t   rx_bit_in,
  input wire logic       rx_bit_ready,
  input var  cci_byte_t  rx_byte_out,
  input wire logic       rx_byte_ready,
  input wire logic       rx_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       tbusy;
  logic       tcod;
  logic       rcod;
  logic [6:0] tlen;
  logic [6:0] tcnt;
  logic [3:0] rcnt;
  logic       take;

  assign take = tx_byte_in.valid && tx_byte_ready;

  // ----------
  // packet tracking
  // ----------
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      tbusy <= 1'b0;
      tcod  <= 1'b0;
      rcod  <= 1'b0;
      tlen  <= 7'h00;
      tcnt  <= 7'h00;
      rcnt  <= 4'h0;
    end
    else if (ce)
    begin
      if (tx_start && !tbusy)
      begin
        tbusy <= 1'b1;
        tcod  <= coding_enable;
        tlen  <= pkt_len;
        tcnt  <= 7'h00;
      end
      else
      begin
        if (tx_done)
          tbusy <= 1'b0;
        if (take)
          tcnt <= tcnt + 7'h01;
      end
      if (rx_start)
      begin
        rcod <= coding_enable;
        rcnt <= 4'h0;
      end
      else if (rx_bit_in.valid && rx_bit_ready)
        rcnt <= rcnt + 4'h1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // ----------
  // properties
  // ----------
  reset_quiet_a: assert property (disable iff (1'b0)
    sys_rst && ce |=> !tx_bit_out.valid && !rx_byte_out.valid && !tx_byte_ready
      && !rx_bit_ready && !tx_done && !rx_done)
    else $error("outputs active after reset");
  first_fetch_a: assert property (
    tx_start && !tbusy |=> tx_byte_ready)
    else $error("no byte request after start");
  coded_lat_a: assert property (
    take && tcod |-> ##18 tx_bit_out.valid)
    else $error("coded bit late");
  raw_lat_a: assert property (
    take && !tcod |-> ##2 tx_bit_out.valid)
    else $error("raw bit late");
  txbit_hold_a: assert property (
    tx_bit_out.valid && !tx_bit_ready |=> tx_bit_out.valid && $stable(tx_bit_out))
    else $error("tx bit changed while stalled");
  rxbyte_hold_a: assert property (
    rx_byte_out.valid && !rx_byte_ready |=> rx_byte_out.valid && $stable(rx_byte_out))
    else $error("rx byte changed while stalled");
  host_bytes_a: assert property (
    tx_done |-> tcnt == tlen)
    else $error("pad byte requested from host");
  block_gap_a: assert property (
    rcod && rx_bit_in.valid && rx_bit_ready && rcnt == 4'hf |=> !rx_bit_ready [*8])
    else $error("bits taken during decode");
  done_pulse_a: assert property (
    tx_done || rx_done |=> !tx_done && !rx_done)
    else $error("done longer than one cycle");

  cover property (tx_done && tcod);
  cover property (rx_done && rcod);
  cover property (rx_done && !rcod);
endmodule
`default_nettype wire

// [verification/cci_codec_tb_top.sv]
// bench for the coded radio path: tx streams checked bit by bit, rx played from the bench coder model
// assumes the modem model sits on the bit side and the bench is the host
`default_nettype none
module cci_codec_tb_top
  import cci_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk, sys_rst, ce, coding_enable, tx_start, tx_byte_ready, tx_bit_ready;
  logic       tx_done, rx_start, rx_bit_ready, rx_byte_ready, rx_done;
  logic [1:0] plm;
  logic [6:0] pkt_len;
  cci_byte_t  tx_byte_in, rx_byte_out;
  cci_bit_t   tx_bit_out, rx_bit_in;
  int         num_errors, num_checks, fidx, nrx, nexp;
  logic [7:0] pl [0:63];
  logic [7:0] got [0:65];
  logic       exp [0:1055];

  cci_codec uut (.mclk(mclk), .sys_rst(sys_rst), .ce(ce), .coding_enable(coding_enable),
    .packet_length_mode(plm), .pkt_len(pkt_len), .tx_start(tx_start),
    .tx_byte_in(tx_byte_in), .tx_byte_ready(tx_byte_ready), .tx_bit_out(tx_bit_out),
    .tx_bit_ready(tx_bit_ready), .tx_done(tx_done), .rx_start(rx_start),
    .rx_bit_in(rx_bit_in), .rx_bit_ready(rx_bit_ready), .rx_byte_out(rx_byte_out),
    .rx_byte_ready(rx_byte_ready), .rx_done(rx_done));
  cci_modem_model m (.mclk(mclk), .sys_rst(sys_rst), .tx_bit_out(tx_bit_out),
    .tx_bit_ready(tx_bit_ready), .rx_bit_in(rx_bit_in), .rx_bit_ready(rx_bit_ready));

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ----------
  // host side feeder and collector
  // ----------
  always @(posedge mclk)
  begin
    rx_byte_ready <= !rx_byte_ready;
    if (rx_byte_out.valid && rx_byte_ready)
    begin
      got[nrx] <= rx_byte_out.data;
      nrx <= nrx + 1;
    end
    if (tx_byte_in.valid && tx_byte_ready)
    begin
      tx_byte_in.valid <= fidx + 1 < pkt_len;
      tx_byte_in.data <= (fidx + 1 < pkt_len) ? pl[fidx + 1] : ~tx_byte_in.data;
      fidx <= fidx + 1;
    end
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // air stream: rate half coder, rows in, columns out
  task automatic build(input bit cod, input int len);
    logic [2:0] sr;
    logic       u;
    logic       blk [0:15];
    logic [7:0] b;
    int         t;
    t = cod ? len + ((len % 2) ? 1 : 2) : len;
    nexp = 0;
    sr = 3'h0;
    for (int i = 0; i < t; i++)
    begin
      b = (i < len) ? pl[i] : 8'h00;
      for (int k = 0; k < 8; k++)
      begin
        u = b[7 - k];
        blk[2 * k] = ^({u, sr} & CCI_G0);
        blk[2 * k + 1] = ^({u, sr} & CCI_G1);
        sr = {sr[1:0], u};
        if (!cod)
          exp[nexp++] = u;
      end
      if (cod)
        for (int j = 0; j < 16; j++)
          exp[nexp++] = blk[(j % 4) * 4 + j / 4];
    end
  endtask

  task automatic start_pkt(input bit cod, input int len, input bit tx);
    @(posedge mclk);
    coding_enable <= cod;
    pkt_len <= len[6:0];
    m.ncap <= 0;
    fidx <= 0;
    nrx <= 0;
    tx_byte_in <= {1'b1, pl[0]};
    tx_start <= tx;
    rx_start <= !tx;
    @(posedge mclk);
    tx_start <= 1'b0;
    rx_start <= 1'b0;
  endtask

  task automatic tx_pkt(input bit cod, input int len);
    build(cod, len);
    start_pkt(cod, len, 1'b1);
    // a second start while busy must be ignored; early, short raw packets end fast
    repeat (3) @(posedge mclk);
    tx_start <= 1'b1;
    @(posedge mclk);
    tx_start <= 1'b0;
    // a hang is left to the watchdog
    while (!tx_done)
      @(negedge mclk);
    repeat (4) @(negedge mclk);
    chk(16'(m.ncap), 16'(nexp));
    for (int i = 0; i < nexp; i++)
      chk(16'(m.cap[i]), 16'(exp[i]));
  endtask

  task automatic rx_pkt(input bit cod, input int len, input int flip);
    build(cod, len);
    if (flip >= 0)
      exp[flip] = ~exp[flip];
    for (int i = 0; i < nexp; i++)
      m.src[i] = exp[i];
    m.nsrc = nexp;
    m.sidx = 0;
    start_pkt(cod, len, 1'b0);
    while (!rx_done)
      @(negedge mclk);
    repeat (4) @(negedge mclk);
    chk(16'(nrx), 16'(len));
    for (int i = 0; i < len; i++)
      chk(16'(got[i]), 16'(pl[i]));
  endtask

  // ----------
  // scenarios
  // ----------
  task automatic test_coded_tx();
    tx_pkt(1'b1, 2);
    m.slow = 1'b1;
    tx_pkt(1'b1, 3);
    tx_pkt(1'b1, 64);
    $display("test coded tx finished");
  endtask

  task automatic test_raw_tx();
    tx_pkt(1'b0, 2);
    m.slow = 1'b0;
    $display("test raw tx finished");
  endtask

  task automatic test_rx();
    rx_pkt(1'b1, 2, -1);
    rx_pkt(1'b1, 5, 9);
    rx_pkt(1'b0, 3, -1);
    $display("test rx finished");
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    num_errors = 0;
    num_checks = 0;
    ce = 1'b1;
    // coding only with fixed length packets
    plm = CCI_LEN_FIXED;
    coding_enable = 1'b0;
    pkt_len = 7'h02;
    tx_start = 1'b0;
    rx_start = 1'b0;
    rx_byte_ready = 1'b0;
    tx_byte_in = '0;
    sys_rst = 1'b1;
    for (int i = 0; i < 64; i++)
      pl[i] = 8'h5a ^ 8'(i * 8'h1d);
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    // payloads stay at two bytes or more
    test_coded_tx();
    test_raw_tx();
    test_rx();
    tally_and_finish();
  end

  initial
  begin
    repeat (60000) @(posedge mclk);
    num_errors++;
    $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    tally_and_finish();
  end
endmodule

bind cci_codec cci_codec_asserts chk_i (.mclk(mclk), .sys_rst(sys_rst), .ce(ce),
  .coding_enable(coding_enable), .pkt_len(pkt_len), .tx_start(tx_start),
  .tx_byte_in(tx_byte_in), .tx_byte_ready(tx_byte_ready), .tx_bit_out(tx_bit_out),
  .tx_bit_ready(tx_bit_ready), .tx_done(tx_done), .rx_start(rx_start),
  .rx_bit_in(rx_bit_in), .rx_bit_ready(rx_bit_ready), .rx_byte_out(rx_byte_out),
  .rx_byte_ready(rx_byte_ready), .rx_done(rx_done));
`default_nettype wire

// [verification/cci_modem_model.sv]
// modem side model: takes tx bits with stalls, plays rx bits from a table
// assumes the bench loads src/nsrc and clears ncap/sidx between packets
`default_nettype none
module cci_modem_model
  import cci_pkg::*;
(
  input  wire logic     mclk,
  input  wire logic     sys_rst,
  input  var  cci_bit_t tx_bit_out,
  output logic          tx_bit_ready,
  output cci_bit_t      rx_bit_in,
  input  wire logic     rx_bit_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       cap [0:1055];
  logic       src [0:1055];
  int         ncap;
  int         nsrc;
  int         sidx;
  bit         slow;
  logic [1:0] st;
  int         nx;

  initial
  begin
    st = 2'h0;
    ncap = 0;
    nsrc = 0;
    sidx = 0;
    slow = 1'b0;
    tx_bit_ready = 1'b0;
    rx_bit_in = '0;
  end

  always @(posedge mclk)
  begin
    nx = sidx + ((rx_bit_in.valid && rx_bit_ready) ? 1 : 0);
    st <= st + 2'h1;
    // slow mode stalls one edge in four
    tx_bit_ready <= !sys_rst && !(slow && st == 2'h0);
    if (tx_bit_out.valid && tx_bit_ready)
    begin
      cap[ncap] <= tx_bit_out.bit_val;
      ncap <= ncap + 1;
    end
    sidx <= nx;
    rx_bit_in.valid <= nx < nsrc;
    // released line shows the inverse, never a stale bit
    rx_bit_in.bit_val <= (nx < nsrc) ? src[nx] : ~rx_bit_in.bit_val;
  end
endmodule
`default_nettype wire
